// File: core/csc_clock_source_select_ctrl.sv
// Clock source select controller with its APB register slave
//
// How it works
// R1 - Bit 7 set: system clocks from PLL, bus half rate; clear: oscillator.
// R2 - Clearing the PLL select bit takes effect only while oscillator qualified.
// R3 - Losing oscillator qualification forces PLL select back to one.
// R4 - Entering full stop sets the PLL select bit.
// R5 - Bit 6 clear: oscillator off in stop; set: pseudo stop keeps it running.
// R6 - Software waits oscillator startup time before entering pseudo stop.
// R7 - Bit 5 set gates aux clock to watchdog during stop; watchdog holds.
// R8 - Stop-disable with watchdog on aux clock: stop entry waits two aux cycles.
// R9 - After stop exit software waits two aux cycles before stopping again.
// R10 - Watchdog source: 00 internal RC, 01 oscillator, 1x auxiliary RC.
// R11 - Any change of watchdog high select restarts the watchdog time-out.
// R12 - Watchdog high select writable to one regardless of oscillator status.
// R13 - With high select set, low select is ignored and restarts nothing.
// R14 - With high select clear, low select change restarts watchdog time-out.
// R15 - Watchdog low select written to one only while oscillator qualified.
// R16 - Losing oscillator qualification clears watchdog low select.
// R17 - Bit 3 keeps tick timer running in pseudo stop if on oscillator.
// R18 - Otherwise the tick timer freezes in stop, counter kept.
// R19 - Bit 2 keeps watchdog running in pseudo stop if on oscillator.
// R20 - Otherwise, except on aux clock with bit 5 clear, the watchdog freezes in stop, counter kept.
// R21 - Bit 1 picks tick clock internal RC or oscillator; change restarts tick.
// R22 - Tick oscillator select set only while qualified, cleared on loss.
// R23 - Writes to the select register ignored unless write protect is zero.
// R24 - Qualified status reads one only when qualified; cleared in full stop.
`timescale 1ns/100ps

module csc_clock_source_select_ctrl (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_qualified,
    input  wire logic        stop_req,
    input  wire logic        stop_wake,
    input  wire logic        aux_clk_tick,
    output logic             sys_clk_from_pll,
    output logic             bus_clk_en,
    output logic             osc_enable,
    output logic       [1:0] wdog_clk_src,
    output logic             tick_clk_from_osc,
    output logic             wdog_run,
    output logic             tick_run,
    output logic             wdog_aux_clk_gated,
    output logic             wdog_restart,
    output logic             tick_restart,
    output logic             stop_active
);

    logic [7:0]                clks_ff;
    logic [7:0]                nxt_clks;
    logic                      wprot_ff;
    logic                      osc_qual_ff;
    logic                      nxt_osc_qual;
    csc_pkg::csc_state_t       state_ff;
    csc_pkg::csc_state_t       nxt_state;
    logic [1:0]                sync_cnt_ff;
    logic [31:0]               prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    logic                      bus_div_ff;
    logic                      pll_sel_ff;
    logic                      osc_en_ff;
    csc_pkg::csc_wd_src_t      wd_src_ff;
    logic                      tick_osc_ff;
    logic                      wdog_run_ff;
    logic                      tick_run_ff;
    logic                      aux_gate_ff;
    logic                      wd_restart_ff;
    logic                      tick_restart_ff;
    logic                      stop_ff;

    logic                      setup_phase;
    logic                      wr_strobe;
    logic                      clks_wr;
    logic                      ctrl_wr;
    logic                      addr_hit;
    logic                      full_stop_entry;
    logic                      in_stop;
    logic                      in_pseudo;
    logic                      wd_on_aux;
    logic                      wd_on_osc;

    assign setup_phase = psel && !penable;
    assign wr_strobe   = psel && penable && pready_ff && pwrite;
    assign clks_wr     = wr_strobe && (paddr == csc_pkg::CSC_ADDR_CLKS) && !wprot_ff; // R23
    assign ctrl_wr     = wr_strobe && (paddr == csc_pkg::CSC_ADDR_CTRL);
    assign addr_hit    = (paddr == csc_pkg::CSC_ADDR_CLKS)
                      || (paddr == csc_pkg::CSC_ADDR_CTRL)
                      || (paddr == csc_pkg::CSC_ADDR_STATUS);

    assign wd_on_aux   = clks_ff[csc_pkg::CSC_BIT_WD_SEL_HI];
    assign wd_on_osc   = !wd_on_aux && clks_ff[csc_pkg::CSC_BIT_WD_SEL_LO];

    // Stop sequencing
    always_comb
    begin
        nxt_state       = state_ff;
        full_stop_entry = 1'b0;
        case (state_ff)
            csc_pkg::CSC_ST_RUN:
            begin
                if (stop_req)
                begin
                    // Aux-clocked watchdog needs its gate crossed before stopping
                    if (clks_ff[csc_pkg::CSC_BIT_AUX_SD] && wd_on_aux)
                        nxt_state = csc_pkg::CSC_ST_SYNC; // R8
                    else if (clks_ff[csc_pkg::CSC_BIT_OSC_RUN])
                        nxt_state = csc_pkg::CSC_ST_PSEUDO_STOP; // R5
                    else
                    begin
                        nxt_state       = csc_pkg::CSC_ST_FULL_STOP; // R5
                        full_stop_entry = 1'b1;
                    end
                end
            end
            csc_pkg::CSC_ST_SYNC:
            begin
                if (aux_clk_tick && (sync_cnt_ff == csc_pkg::CSC_AUX_SYNC_CYC - 2'h1))
                begin
                    if (clks_ff[csc_pkg::CSC_BIT_OSC_RUN])
                        nxt_state = csc_pkg::CSC_ST_PSEUDO_STOP;
                    else
                    begin
                        nxt_state       = csc_pkg::CSC_ST_FULL_STOP;
                        full_stop_entry = 1'b1;
                    end
                end
            end
            csc_pkg::CSC_ST_FULL_STOP,
            csc_pkg::CSC_ST_PSEUDO_STOP:
            begin
                if (stop_wake)
                    nxt_state = csc_pkg::CSC_ST_RUN;
            end
            default: nxt_state = csc_pkg::CSC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_ff <= csc_pkg::CSC_ST_RUN;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Counts aux clock ticks while stop entry is held off
    always_ff @(posedge clk)
    begin
        if (sys_rst || state_ff != csc_pkg::CSC_ST_SYNC)
        begin
            sync_cnt_ff <= 2'h0;
        end
        else if (aux_clk_tick)
        begin
            sync_cnt_ff <= sync_cnt_ff + 2'h1; // R8
        end
    end

    assign in_stop   = (state_ff == csc_pkg::CSC_ST_FULL_STOP)
                    || (state_ff == csc_pkg::CSC_ST_PSEUDO_STOP);
    assign in_pseudo = (state_ff == csc_pkg::CSC_ST_PSEUDO_STOP);

    // Qualified status: follows the monitor but is dropped in full stop
    always_comb
    begin
        nxt_osc_qual = osc_qualified;
        if (full_stop_entry || state_ff == csc_pkg::CSC_ST_FULL_STOP)
            nxt_osc_qual = 1'b0; // R24
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            osc_qual_ff <= 1'b0;
        end
        else
        begin
            osc_qual_ff <= nxt_osc_qual; // R24
        end
    end

    // Select register: hardware overrides win over a software write
    always_comb
    begin
        nxt_clks = clks_ff;
        if (clks_wr)
        begin
            nxt_clks = pwdata[7:0];
            // PLL select may only drop while oscillator is good
            if (!osc_qual_ff)
            begin
                nxt_clks[csc_pkg::CSC_BIT_PLL_SEL] = 1'b1; // R2
            end
            nxt_clks[csc_pkg::CSC_BIT_WD_SEL_LO] =
                pwdata[csc_pkg::CSC_BIT_WD_SEL_LO] && osc_qual_ff; // R15
            nxt_clks[csc_pkg::CSC_BIT_TICK_SEL] =
                pwdata[csc_pkg::CSC_BIT_TICK_SEL] && osc_qual_ff; // R22
            // High select takes its written value unconditionally
            nxt_clks[csc_pkg::CSC_BIT_WD_SEL_HI] = pwdata[csc_pkg::CSC_BIT_WD_SEL_HI]; // R12
        end
        // Held as a level so a clock left on a dead oscillator cannot persist
        if (!osc_qual_ff)
        begin
            nxt_clks[csc_pkg::CSC_BIT_PLL_SEL]   = 1'b1; // R3
            nxt_clks[csc_pkg::CSC_BIT_WD_SEL_LO] = 1'b0; // R16
            nxt_clks[csc_pkg::CSC_BIT_TICK_SEL]  = 1'b0; // R22
        end
        if (full_stop_entry)
        begin
            nxt_clks[csc_pkg::CSC_BIT_PLL_SEL] = 1'b1; // R4
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            clks_ff <= csc_pkg::CSC_CLKS_RST;
        end
        else
        begin
            clks_ff <= nxt_clks;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wprot_ff <= csc_pkg::CSC_WPROT_RST;
        end
        else if (ctrl_wr)
        begin
            wprot_ff <= pwdata[csc_pkg::CSC_BIT_WPROT];
        end
    end

    // Restart pulses, raised in the same cycle that the select bit changes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wd_restart_ff   <= 1'b0;
            tick_restart_ff <= 1'b0;
        end
        else
        begin
            wd_restart_ff <=
                (nxt_clks[csc_pkg::CSC_BIT_WD_SEL_HI] != clks_ff[csc_pkg::CSC_BIT_WD_SEL_HI]) // R11
                || (!clks_ff[csc_pkg::CSC_BIT_WD_SEL_HI]
                    && !nxt_clks[csc_pkg::CSC_BIT_WD_SEL_HI]
                    && (nxt_clks[csc_pkg::CSC_BIT_WD_SEL_LO]
                        != clks_ff[csc_pkg::CSC_BIT_WD_SEL_LO])); // R13 R14
            tick_restart_ff <=
                nxt_clks[csc_pkg::CSC_BIT_TICK_SEL] != clks_ff[csc_pkg::CSC_BIT_TICK_SEL]; // R21
        end
    end

    // Clock source choices seen by the system clock and the timers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pll_sel_ff  <= 1'b1;
            wd_src_ff   <= csc_pkg::CSC_SRC_IRC;
            tick_osc_ff <= 1'b0;
        end
        else
        begin
            pll_sel_ff <= clks_ff[csc_pkg::CSC_BIT_PLL_SEL]; // R1
            if (wd_on_aux)
            begin
                wd_src_ff <= csc_pkg::CSC_SRC_AUX; // R10 R13
            end
            else if (wd_on_osc)
            begin
                wd_src_ff <= csc_pkg::CSC_SRC_OSC; // R10
            end
            else
            begin
                wd_src_ff <= csc_pkg::CSC_SRC_IRC; // R10
            end
            tick_osc_ff <= clks_ff[csc_pkg::CSC_BIT_TICK_SEL]; // R21
        end
    end

    // Bus runs at half the selected system clock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_div_ff <= 1'b0;
        end
        else
        begin
            bus_div_ff <= !bus_div_ff; // R1
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            osc_en_ff   <= 1'b1;
            stop_ff     <= 1'b0;
            aux_gate_ff <= 1'b0;
            wdog_run_ff <= 1'b1;
            tick_run_ff <= 1'b1;
        end
        else
        begin
            osc_en_ff   <= (state_ff != csc_pkg::CSC_ST_FULL_STOP); // R5
            stop_ff     <= in_stop;
            aux_gate_ff <= in_stop && clks_ff[csc_pkg::CSC_BIT_AUX_SD]; // R7
            if (!in_stop)
            begin
                wdog_run_ff <= 1'b1;
                tick_run_ff <= 1'b1;
            end
            else
            begin
                // Timers freeze rather than reset, so counts resume on exit
                if (wd_on_aux)
                begin
                    wdog_run_ff <= !clks_ff[csc_pkg::CSC_BIT_AUX_SD]; // R7
                end
                else
                begin
                    wdog_run_ff <= in_pseudo && wd_on_osc
                                && clks_ff[csc_pkg::CSC_BIT_WD_PSE]; // R19 R20
                end
                tick_run_ff <= in_pseudo && clks_ff[csc_pkg::CSC_BIT_TICK_SEL]
                            && clks_ff[csc_pkg::CSC_BIT_TICK_PSE]; // R17 R18
            end
        end
    end

    // APB slave: data prepared in setup so access completes without wait
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= setup_phase;
            pslverr_ff <= setup_phase && !addr_hit;
            prdata_ff  <= 32'h0000_0000;
            if (setup_phase && !pwrite)
            begin
                case (paddr)
                    csc_pkg::CSC_ADDR_CLKS: prdata_ff <= {24'h00_0000, clks_ff};
                    csc_pkg::CSC_ADDR_CTRL: prdata_ff <= {31'h0000_0000, wprot_ff};
                    csc_pkg::CSC_ADDR_STATUS:
                    begin
                        prdata_ff <= {29'h0000_0000, state_ff, osc_qual_ff}; // R24
                    end
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign sys_clk_from_pll   = pll_sel_ff;
    assign bus_clk_en         = bus_div_ff;
    assign osc_enable         = osc_en_ff;
    assign wdog_clk_src       = wd_src_ff;
    assign tick_clk_from_osc  = tick_osc_ff;
    assign wdog_run           = wdog_run_ff;
    assign tick_run           = tick_run_ff;
    assign wdog_aux_clk_gated = aux_gate_ff;
    assign wdog_restart       = wd_restart_ff;
    assign tick_restart       = tick_restart_ff;
    assign stop_active        = stop_ff;

endmodule

// File: core/csc_pkg.sv
// Constants and types shared by the clock source select controller
package csc_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] CSC_ADDR_CLKS   = 8'h00;
    localparam logic [7:0] CSC_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] CSC_ADDR_STATUS = 8'h08;

    // Field positions of clock_source_select
    localparam int CSC_BIT_PLL_SEL    = 7;
    localparam int CSC_BIT_OSC_RUN    = 6;
    localparam int CSC_BIT_AUX_SD     = 5;
    localparam int CSC_BIT_WD_SEL_HI  = 4;
    localparam int CSC_BIT_TICK_PSE   = 3;
    localparam int CSC_BIT_WD_PSE     = 2;
    localparam int CSC_BIT_TICK_SEL   = 1;
    localparam int CSC_BIT_WD_SEL_LO  = 0;

    // Field positions of the control and status words
    localparam int CSC_BIT_WPROT      = 0;
    localparam int CSC_BIT_OSC_QUAL   = 0;
    localparam int CSC_BIT_STATE_LSB  = 1;

    // Values after reset
    localparam logic [7:0] CSC_CLKS_RST  = 8'h80;
    localparam logic       CSC_WPROT_RST = 1'b0;

    // Auxiliary clock cycles of stop entry synchronisation
    localparam logic [1:0] CSC_AUX_SYNC_CYC = 2'h2;

    typedef enum logic [1:0] {
        CSC_SRC_IRC,
        CSC_SRC_OSC,
        CSC_SRC_AUX
    } csc_wd_src_t;

    typedef enum logic [1:0] {
        CSC_ST_RUN,
        CSC_ST_SYNC,
        CSC_ST_FULL_STOP,
        CSC_ST_PSEUDO_STOP
    } csc_state_t;

endpackage

// File: test/csc_clock_source_select_ctrl_bench.sv
// Self-checking APB bench for the clock source select controller
`timescale 1ns/100ps
module csc_clock_source_select_ctrl_bench;
    localparam logic [7:0] A_CLKS = csc_pkg::CSC_ADDR_CLKS;
    localparam logic [7:0] A_CTRL = csc_pkg::CSC_ADDR_CTRL;
    localparam logic [7:0] A_STAT = csc_pkg::CSC_ADDR_STATUS;
    logic        clk, sys_rst, psel, penable, pwrite, osc_qualified;
    logic        stop_req, stop_wake, aux_clk_tick, pready, pslverr, er;
    logic        sys_clk_from_pll, bus_clk_en, osc_enable, tick_clk_from_osc;
    logic        wdog_run, tick_run, wdog_aux_clk_gated, wdog_restart, tick_restart;
    logic        stop_active;
    logic [1:0]  wdog_clk_src;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, compares, cyc, wd_n, tk_n;

    csc_clock_source_select_ctrl u_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_qualified(osc_qualified), .stop_req(stop_req), .stop_wake(stop_wake),
        .aux_clk_tick(aux_clk_tick), .sys_clk_from_pll(sys_clk_from_pll),
        .bus_clk_en(bus_clk_en), .osc_enable(osc_enable), .wdog_clk_src(wdog_clk_src),
        .tick_clk_from_osc(tick_clk_from_osc), .wdog_run(wdog_run), .tick_run(tick_run),
        .wdog_aux_clk_gated(wdog_aux_clk_gated), .wdog_restart(wdog_restart),
        .tick_restart(tick_restart), .stop_active(stop_active)
    );

    always #10 clk = ~clk;

    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Restart pulses last one cycle, so each is counted at the edge that ends it
    always @(posedge clk)
    begin
        cyc++;
        if (wdog_restart === 1'b1) wd_n++;
        if (tick_restart === 1'b1) tk_n++;
        if (cyc > 3000)
        begin
            miscompares++;
            report_and_stop;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Starts one edge late so a release and a new setup never share a time step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the bench timeout ends a wait for ready
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "register read");
    endtask

    task wr_restart(input logic [7:0] v, input logic [31:0] exp, input int dw, input int dt);
        int w0;
        int t0;
        w0 = wd_n;
        t0 = tk_n;
        apb(1'b1, A_CLKS, {24'h0, v});
        idle(3);
        rchk(A_CLKS, exp);
        check(32'(wd_n - w0), 32'(dw), "watchdog restarts");
        check(32'(tk_n - t0), 32'(dt), "tick restarts");
    endtask

    task pulse_stop;
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
    endtask

    task wake;
        @(posedge clk);
        stop_wake <= 1'b1;
        @(posedge clk);
        stop_wake <= 1'b0;
        idle(3);
        check(32'(stop_active), 32'h0, "awake");
        check(32'(wdog_run), 32'h1, "watchdog resumed");
    endtask

    task stop_cycle(input logic [7:0] v, input logic [31:0] st, input logic wd, input logic tk);
        apb(1'b1, A_CLKS, {24'h0, v});
        pulse_stop;
        idle(3);
        check(32'(stop_active), 32'h1, "in stop");
        check(32'(osc_enable), 32'(v[6]), "oscillator in stop");
        check(32'(wdog_run), 32'(wd), "watchdog in stop");
        check(32'(tick_run), 32'(tk), "tick in stop");
        rchk(A_STAT, st);
        wake;
    endtask

    initial
    begin
        {clk, psel, penable, pwrite, paddr, pwdata, osc_qualified} = '0;
        {stop_req, stop_wake, aux_clk_tick} = '0;
        {miscompares, compares, cyc, wd_n, tk_n} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(A_CLKS, 32'h80);
        rchk(A_CTRL, 32'h0);
        rchk(A_STAT, 32'h0);
        rchk(8'h0C, 32'h0);
        check(32'(er), 32'h1, "unmapped error");
        check(32'(sys_clk_from_pll), 32'h1, "pll source");
        $display("test reset done");
        wr_restart(8'h03, 32'h80, 0, 0);
        wr_restart(8'h10, 32'h90, 1, 0);
        check(32'(wdog_clk_src), 32'h2, "aux source");
        osc_qualified <= 1'b1;
        idle(3);
        wr_restart(8'h11, 32'h11, 0, 0);
        wr_restart(8'h03, 32'h03, 1, 1);
        check(32'(wdog_clk_src), 32'h1, "osc source");
        check(32'(tick_clk_from_osc), 32'h1, "tick on osc");
        check(32'(sys_clk_from_pll), 32'h0, "osc system clock");
        wr_restart(8'h02, 32'h02, 1, 0);
        check(32'(wdog_clk_src), 32'h0, "irc source");
        wr_restart(8'h03, 32'h03, 1, 0);
        $display("test select done");
        apb(1'b1, A_CTRL, 32'h1);
        rchk(A_CTRL, 32'h1);
        wr_restart(8'h80, 32'h03, 0, 0);
        apb(1'b1, A_CTRL, 32'h0);
        osc_qualified <= 1'b0;
        idle(5);
        rchk(A_CLKS, 32'h80);
        rchk(A_STAT, 32'h0);
        osc_qualified <= 1'b1;
        idle(3);
        rchk(A_STAT, 32'h1);
        $display("test protect and loss done");
        stop_cycle(8'h00, 32'h04, 1'b0, 1'b0);
        rchk(A_CLKS, 32'h80);
        // Oscillator startup allowance after leaving full stop
        idle(20);
        stop_cycle(8'h4E, 32'h07, 1'b0, 1'b1);
        stop_cycle(8'h4F, 32'h07, 1'b1, 1'b1);
        stop_cycle(8'h47, 32'h07, 1'b1, 1'b0);
        $display("test stop done");
        apb(1'b1, A_CLKS, 32'h30);
        pulse_stop;
        idle(3);
        rchk(A_STAT, 32'h03);
        for (int i = 0; i < 2; i++)
        begin
            check(32'(stop_active), 32'h0, "waiting for aux sync");
            @(posedge clk);
            aux_clk_tick <= 1'b1;
            @(posedge clk);
            aux_clk_tick <= 1'b0;
            idle(2);
        end
        idle(2);
        check(32'(stop_active), 32'h1, "stop after sync");
        check(32'(wdog_aux_clk_gated), 32'h1, "aux gated");
        check(32'(wdog_run), 32'h0, "watchdog held");
        wake;
        // Software waits two aux cycles before any further stop
        repeat (2)
        begin
            @(posedge clk);
            aux_clk_tick <= 1'b1;
            @(posedge clk);
            aux_clk_tick <= 1'b0;
        end
        $display("test aux sync done");
        report_and_stop;
    end
endmodule

// File: test/csc_ctrl_asserts.sv
// Port-level concurrent checks for the clock source select controller
`timescale 1ns/100ps
module csc_ctrl_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_qualified,
    input wire logic        sys_clk_from_pll,
    input wire logic        bus_clk_en,
    input wire logic        osc_enable,
    input wire logic [1:0]  wdog_clk_src,
    input wire logic        tick_clk_from_osc,
    input wire logic        wdog_run,
    input wire logic        tick_run,
    input wire logic        wdog_aux_clk_gated,
    input wire logic        wdog_restart,
    input wire logic        stop_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_apb_one_wait: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("access phase not one cycle");
    a_idle_read_zero: assert property (
        !pready |-> prdata == 32'h0 && !pslverr) else $error("read data outside access");
    a_bus_half_rate: assert property (
        !$past(sys_rst) |-> bus_clk_en != $past(bus_clk_en)) else $error("bus enable not half rate");
    // Bench holds the loss for several cycles, so four cycles bound the override
    a_osc_loss_force: assert property (
        $fell(osc_qualified) |-> ##[1:4] (sys_clk_from_pll && !tick_clk_from_osc
        && wdog_clk_src != 2'h1)) else $error("oscillator loss not forced");
    a_full_stop_pll: assert property (
        !osc_enable [*3] |-> sys_clk_from_pll) else $error("full stop without pll source");
    a_aux_gate_hold: assert property (
        wdog_aux_clk_gated && wdog_clk_src == 2'h2 |-> !wdog_run)
        else $error("gated watchdog still running");
    a_stop_resume: assert property (
        $fell(stop_active) |-> ##[0:1] (wdog_run && tick_run)) else $error("timers not resumed");
    a_wd_src_code: assert property (
        wdog_clk_src != 2'h3) else $error("illegal watchdog source");
    // Restart leads the registered source by one cycle, in both directions
    a_restart_pulse: assert property (
        wdog_restart |=> $changed(wdog_clk_src)) else $error("restart without source change");
    a_src_change_restart: assert property (
        $changed(wdog_clk_src) |-> $past(wdog_restart)) else $error("source change without restart");
endmodule

bind csc_clock_source_select_ctrl csc_ctrl_asserts u_chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_qualified(osc_qualified),
    .sys_clk_from_pll(sys_clk_from_pll), .bus_clk_en(bus_clk_en), .osc_enable(osc_enable),
    .wdog_clk_src(wdog_clk_src), .tick_clk_from_osc(tick_clk_from_osc), .wdog_run(wdog_run),
    .tick_run(tick_run), .wdog_aux_clk_gated(wdog_aux_clk_gated),
    .wdog_restart(wdog_restart), .stop_active(stop_active)
);
